/* pmc_pkg.sv */
// constants, state type and timing figures for the pack power-mode control
// assumes a 50 MHz core clock and a register port from the bus engine
package pmc_pkg;
    // register addresses on the internal register port
    localparam logic [7:0] PROT_REG_ADDR = 8'h00;
    localparam logic [7:0] CTRL_REG_ADDR = 8'h60;
    // control register field positions
    localparam int CTRL_NEG_BLANK_BIT = 7;
    localparam int CTRL_UV_SLEEP_BIT = 6;
    localparam int CTRL_BUS_LOW_BIT = 5;
    localparam int CTRL_NET_OPC_BIT = 4;
    localparam int CTRL_RSVD_ZERO_BIT = 3;
    localparam int CTRL_PIO_WAKE_BIT = 2;
    localparam int CTRL_DQ_WAKE_BIT = 1;
    // protection register gate enable positions
    localparam int PROT_CE_BIT = 1;
    localparam int PROT_DE_BIT = 0;
    // values held during reset, before the nonvolatile recall
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] GATE_EN_RESET = 2'h3;
    // net-address opcodes
    localparam logic [7:0] NET_ADDR_OPC_LO = 8'h33;
    localparam logic [7:0] NET_ADDR_OPC_HI = 8'h39;
    // timing: figures in their own unit, then cycle counts
    localparam int CLK_HZ = 50_000_000;
    localparam int SLEEP_TIMEOUT_MS = 2000;
    localparam int WAKE_DEBOUNCE_MS = 100;
    localparam int SLEEP_TIMEOUT_CYC = (CLK_HZ / 1000) * SLEEP_TIMEOUT_MS;
    localparam int WAKE_DEBOUNCE_CYC = (CLK_HZ / 1000) * WAKE_DEBOUNCE_MS;
    localparam int TIMER_W = 32;
    // synchroniser lane positions for pin-side inputs
    localparam int SYN_DQ = 0;
    localparam int SYN_PIO = 1;
    localparam int SYN_CHARGER = 2;
    localparam int SYN_CHG_CUR = 3;
    localparam int SYN_UNDERV = 4;
    localparam int SYN_CC_SAFE = 5;
    localparam int SYN_DC_SAFE = 6;
    localparam int SYN_N = 7;
    // power modes
    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_SLEEP_BUS,
        PMC_SLEEP_UV
    } pmc_state_t;
endpackage

/* pmc_hold_timer.sv */
// counts cycles while a condition holds, restarting when it lapses
// assumes run comes from logic on the same clock
`timescale 1ns/1ps
module pmc_hold_timer #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // condition and target
    input wire logic run,
    input wire logic [WIDTH-1:0] limit,
    // result
    output logic done
);
    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    // saturating count; drop of run restarts from zero
    always_comb begin
        if (!run) begin
            nxt_cnt = '0;
        end else if (cnt_ff == limit) begin
            nxt_cnt = cnt_ff;
        end else begin
            nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end
        nxt_done = run && (nxt_cnt == limit);
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;
endmodule

/* pmc_power_mode_ctrl.sv */
// active/sleep mode controller with control register and wake logic
// assumes comparator results arrive as async pins; bus engine and
// measurement logic share CLK
`timescale 1ns/1ps
module pmc_power_mode_ctrl #(
    parameter int SLEEP_CYC = pmc_pkg::SLEEP_TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = pmc_pkg::WAKE_DEBOUNCE_CYC,
    parameter int CUR_W = 16,
    parameter int BLANK_LIMIT = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // pins and analog comparators, asynchronous
    input wire logic DQ_IN,
    input wire logic PIO_IN,
    input wire logic CHARGER_DET,
    input wire logic CHG_CURRENT_DET,
    input wire logic UNDERV_DET,
    input wire logic CC_SAFE,
    input wire logic DC_SAFE,
    // pin pull controls
    output logic DQ_PULLDOWN_EN,
    output logic DQ_PULLUP_EN,
    output logic PIO_PULLUP_EN,
    // switch drives
    output logic CHARGE_SWITCH_DRIVE,
    output logic DISCHARGE_SWITCH_DRIVE,
    // register port from the bus engine
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    output logic [7:0] REG_RDATA,
    // nonvolatile copy
    input wire logic [7:0] NV_CFG,
    input wire logic COPY_DATA,
    output logic NV_WR_STB,
    output logic [7:0] NV_WR_DATA,
    // measurement path
    input wire logic signed [CUR_W-1:0] CURRENT_RAW,
    input wire logic CURRENT_VALID,
    output logic signed [CUR_W-1:0] CURRENT_OUT,
    output logic MEAS_EN,
    // authentication requests
    input wire logic SHA_REQ,
    output logic SHA_START,
    output logic SHA_REFUSED,
    // mode and command decode
    output logic ACTIVE,
    output logic [7:0] NET_ADDR_OPCODE
);
    // two-flop synchronisers
    logic [pmc_pkg::SYN_N-1:0] async_in;
    logic [pmc_pkg::SYN_N-1:0] meta_ff;
    logic [pmc_pkg::SYN_N-1:0] sync_ff;
    assign async_in = {DC_SAFE, CC_SAFE, UNDERV_DET, CHG_CURRENT_DET,
                       CHARGER_DET, PIO_IN, DQ_IN};

    genvar gi;
    generate
        for (gi = 0; gi < pmc_pkg::SYN_N; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    logic dq;
    logic programmable_wake_pin;
    logic charger;
    logic chg_cur;
    logic underv;
    assign dq = sync_ff[pmc_pkg::SYN_DQ];
    assign programmable_wake_pin = sync_ff[pmc_pkg::SYN_PIO];
    assign charger = sync_ff[pmc_pkg::SYN_CHARGER];
    assign chg_cur = sync_ff[pmc_pkg::SYN_CHG_CUR];
    assign underv = sync_ff[pmc_pkg::SYN_UNDERV];

    // address match, used by both write and read paths
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] ref_a);
        addr_hit = (a == ref_a);
    endfunction

    // state
    pmc_pkg::pmc_state_t state_ff;
    pmc_pkg::pmc_state_t nxt_state;
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic loaded_ff;
    logic nxt_loaded;
    logic [1:0] gate_en_ff;
    logic [1:0] nxt_gate_en;
    logic dq_prev_ff;
    logic nxt_dq_prev;
    logic dq_ref_ff;
    logic nxt_dq_ref;
    logic dq_arm_ff;
    logic nxt_dq_arm;
    logic pio_arm_ff;
    logic nxt_pio_arm;

    // timers
    logic static_run;
    logic static_done;
    logic wake_run;
    logic wake_done;
    logic sleep_block;
    logic enter_bus;
    logic enter_uv;
    logic wake_now;
    logic waking;

    // data pin static timer, restarts on any edge and while asleep
    assign static_run = (state_ff == pmc_pkg::PMC_ACTIVE) &&
                        (dq == dq_prev_ff);
    pmc_hold_timer #(
        .WIDTH(pmc_pkg::TIMER_W)
    ) u_static_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .run(static_run),
        .limit(pmc_pkg::TIMER_W'(SLEEP_CYC)),
        .done(static_done)
    );

    // wake pin condition; any lapse restarts the debounce
    always_comb begin
        wake_run = 1'b0;
        case (state_ff)
            pmc_pkg::PMC_SLEEP_BUS: begin
                wake_run = (dq && !dq_ref_ff);
            end
            pmc_pkg::PMC_SLEEP_UV: begin
                wake_run = (dq != dq_ref_ff);
            end
            default: begin
                wake_run = 1'b0;
            end
        endcase
        if (state_ff != pmc_pkg::PMC_ACTIVE) begin
            if ((dq_arm_ff && !dq) || (pio_arm_ff && !programmable_wake_pin)) begin
                wake_run = 1'b1;
            end
        end
    end

    pmc_hold_timer #(
        .WIDTH(pmc_pkg::TIMER_W)
    ) u_wake_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .run(wake_run),
        .limit(pmc_pkg::TIMER_W'(DEBOUNCE_CYC)),
        .done(wake_done)
    );

    // sleep entry and exit decisions; static_run masks the done flag,
    // which lingers one cycle past a pin edge and would skip the timeout
    assign sleep_block = charger || chg_cur;
    assign enter_bus = ctrl_ff[pmc_pkg::CTRL_BUS_LOW_BIT] && !dq &&
                       static_run && static_done && !sleep_block;
    assign enter_uv = ctrl_ff[pmc_pkg::CTRL_UV_SLEEP_BIT] && underv &&
                      static_run && static_done && !sleep_block;
    assign wake_now = wake_done || (charger && !underv);
    assign waking = (state_ff != pmc_pkg::PMC_ACTIVE) && wake_now;

    // mode sequencing; undervoltage path wins so any dq change wakes it
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pmc_pkg::PMC_ACTIVE: begin
                if (loaded_ff && enter_uv) begin
                    nxt_state = pmc_pkg::PMC_SLEEP_UV;
                end else if (loaded_ff && enter_bus) begin
                    nxt_state = pmc_pkg::PMC_SLEEP_BUS;
                end
            end
            pmc_pkg::PMC_SLEEP_BUS, pmc_pkg::PMC_SLEEP_UV: begin
                if (wake_now) begin
                    nxt_state = pmc_pkg::PMC_ACTIVE;
                end
            end
            default: begin
                nxt_state = pmc_pkg::PMC_ACTIVE;
            end
        endcase
    end

    // wake pin arming: pullup first, arm once the pin reads high
    always_comb begin
        nxt_dq_prev = dq;
        nxt_dq_ref = dq_ref_ff;
        nxt_dq_arm = dq_arm_ff;
        nxt_pio_arm = pio_arm_ff;
        if (state_ff == pmc_pkg::PMC_ACTIVE) begin
            nxt_dq_ref = dq;
            nxt_dq_arm = 1'b0;
            nxt_pio_arm = 1'b0;
        end else begin
            if (ctrl_ff[pmc_pkg::CTRL_DQ_WAKE_BIT] && !dq_arm_ff && dq) begin
                nxt_dq_arm = 1'b1;
                nxt_dq_ref = 1'b1; // own pullup rise is not a wake
            end
            if (ctrl_ff[pmc_pkg::CTRL_PIO_WAKE_BIT] && !pio_arm_ff && programmable_wake_pin) begin
                nxt_pio_arm = 1'b1;
            end
        end
        if (waking) begin
            nxt_dq_arm = 1'b0;
            nxt_pio_arm = 1'b0;
        end
    end

    // control register: nonvolatile recall once, then shadow writes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_loaded = 1'b1;
        if (!loaded_ff) begin
            nxt_ctrl = NV_CFG;
        end else if (REG_WR && addr_hit(REG_ADDR, pmc_pkg::CTRL_REG_ADDR)) begin
            nxt_ctrl = REG_WDATA;
        end
    end

    // gate enables: set on wake, clearable only while active
    always_comb begin
        nxt_gate_en = gate_en_ff;
        if (waking) begin
            nxt_gate_en = pmc_pkg::GATE_EN_RESET;
        end else if (state_ff == pmc_pkg::PMC_ACTIVE && REG_WR &&
                     addr_hit(REG_ADDR, pmc_pkg::PROT_REG_ADDR)) begin
            nxt_gate_en[pmc_pkg::PROT_CE_BIT] =
                REG_WDATA[pmc_pkg::PROT_CE_BIT];
            nxt_gate_en[pmc_pkg::PROT_DE_BIT] =
                REG_WDATA[pmc_pkg::PROT_DE_BIT];
        end
    end

    // core state registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_ff <= pmc_pkg::PMC_ACTIVE;
            ctrl_ff <= pmc_pkg::CTRL_RESET;
            loaded_ff <= 1'b0;
            gate_en_ff <= pmc_pkg::GATE_EN_RESET;
            dq_prev_ff <= 1'b0;
            dq_ref_ff <= 1'b0;
            dq_arm_ff <= 1'b0;
            pio_arm_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ctrl_ff <= nxt_ctrl;
            loaded_ff <= nxt_loaded;
            gate_en_ff <= nxt_gate_en;
            dq_prev_ff <= nxt_dq_prev;
            dq_ref_ff <= nxt_dq_ref;
            dq_arm_ff <= nxt_dq_arm;
            pio_arm_ff <= nxt_pio_arm;
        end
    end

    // output next values
    logic act;
    logic nxt_cc;
    logic nxt_dc;
    logic nxt_dq_pu;
    logic nxt_pio_pu;
    logic [7:0] nxt_rdata;
    logic signed [CUR_W-1:0] nxt_cur;
    logic nxt_sha_start;
    logic nxt_sha_refused;
    logic nxt_nv_stb;
    logic [7:0] nxt_opc;
    assign act = (nxt_state == pmc_pkg::PMC_ACTIVE);

    always_comb begin
        // drives only when awake and the protector calls it safe
        nxt_cc = act && nxt_gate_en[pmc_pkg::PROT_CE_BIT] &&
                 sync_ff[pmc_pkg::SYN_CC_SAFE];
        nxt_dc = act && nxt_gate_en[pmc_pkg::PROT_DE_BIT] &&
                 sync_ff[pmc_pkg::SYN_DC_SAFE];
        // weak pullups only while asleep with the wake enabled
        nxt_dq_pu = !act && nxt_ctrl[pmc_pkg::CTRL_DQ_WAKE_BIT];
        nxt_pio_pu = !act && nxt_ctrl[pmc_pkg::CTRL_PIO_WAKE_BIT];
        // reading held in sleep; small negatives blanked on request
        nxt_cur = CURRENT_OUT;
        if (act && CURRENT_VALID) begin
            nxt_cur = CURRENT_RAW;
            if (ctrl_ff[pmc_pkg::CTRL_NEG_BLANK_BIT] && CURRENT_RAW < 0 &&
                CURRENT_RAW >= -CUR_W'(BLANK_LIMIT)) begin
                nxt_cur = '0;
            end
        end
        nxt_sha_start = SHA_REQ && state_ff == pmc_pkg::PMC_ACTIVE;
        nxt_sha_refused = SHA_REQ && state_ff != pmc_pkg::PMC_ACTIVE;
        nxt_nv_stb = COPY_DATA && loaded_ff;
        nxt_opc = ctrl_ff[pmc_pkg::CTRL_NET_OPC_BIT] ?
                  pmc_pkg::NET_ADDR_OPC_HI : pmc_pkg::NET_ADDR_OPC_LO;
        // read-back; unmapped addresses read zero
        nxt_rdata = 8'h00;
        if (addr_hit(REG_ADDR, pmc_pkg::CTRL_REG_ADDR)) begin
            nxt_rdata = ctrl_ff;
        end else if (addr_hit(REG_ADDR, pmc_pkg::PROT_REG_ADDR)) begin
            nxt_rdata = {6'h00, gate_en_ff};
        end
    end

    // output registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ACTIVE <= 1'b1;
            MEAS_EN <= 1'b0;
            CHARGE_SWITCH_DRIVE <= 1'b0;
            DISCHARGE_SWITCH_DRIVE <= 1'b0;
            DQ_PULLDOWN_EN <= 1'b1;
            DQ_PULLUP_EN <= 1'b0;
            PIO_PULLUP_EN <= 1'b0;
            REG_RDATA <= 8'h00;
            CURRENT_OUT <= '0;
            SHA_START <= 1'b0;
            SHA_REFUSED <= 1'b0;
            NV_WR_STB <= 1'b0;
            NV_WR_DATA <= 8'h00;
            NET_ADDR_OPCODE <= pmc_pkg::NET_ADDR_OPC_LO;
        end else begin
            ACTIVE <= act;
            MEAS_EN <= act;
            CHARGE_SWITCH_DRIVE <= nxt_cc;
            DISCHARGE_SWITCH_DRIVE <= nxt_dc;
            // pulldown yields only where the wake pullup takes the pin
            DQ_PULLDOWN_EN <= !nxt_dq_pu;
            DQ_PULLUP_EN <= nxt_dq_pu;
            PIO_PULLUP_EN <= nxt_pio_pu;
            REG_RDATA <= nxt_rdata;
            CURRENT_OUT <= nxt_cur;
            SHA_START <= nxt_sha_start;
            SHA_REFUSED <= nxt_sha_refused;
            NV_WR_STB <= nxt_nv_stb;
            NV_WR_DATA <= ctrl_ff;
            NET_ADDR_OPCODE <= nxt_opc;
        end
    end
endmodule

/* pmc_monitor.sv */
// checker for the power-mode controller, watching top-level ports only
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module pmc_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // requests
    input wire logic CHARGER_DET,
    input wire logic SHA_REQ,
    input wire logic COPY_DATA,
    // mode and drives
    input wire logic ACTIVE,
    input wire logic MEAS_EN,
    input wire logic CHARGE_SWITCH_DRIVE,
    input wire logic DISCHARGE_SWITCH_DRIVE,
    // answers
    input wire logic SHA_START,
    input wire logic SHA_REFUSED,
    input wire logic NV_WR_STB,
    // pulls and decode
    input wire logic DQ_PULLDOWN_EN,
    input wire logic DQ_PULLUP_EN,
    input wire logic PIO_PULLUP_EN,
    input wire logic [7:0] NET_ADDR_OPCODE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // sleep must never leave a protection switch on
    sleep_drv_off_a: assert property (
        !ACTIVE |-> !CHARGE_SWITCH_DRIVE && !DISCHARGE_SWITCH_DRIVE)
        else $error("switch drive on while asleep");
    sleep_meas_a: assert property (
        !ACTIVE |-> !MEAS_EN) else $error("measuring while asleep");
    active_meas_a: assert property (
        ACTIVE [*3] |-> MEAS_EN) else $error("not measuring while active");
    sha_refuse_a: assert property (
        SHA_REQ && !ACTIVE |=> SHA_REFUSED && !SHA_START)
        else $error("hash request not refused asleep");
    sha_start_a: assert property (
        SHA_REQ && ACTIVE |=> SHA_START && !SHA_REFUSED)
        else $error("hash request not started active");
    charger_hold_a: assert property (
        CHARGER_DET [*6] ##0 ACTIVE |=> ACTIVE)
        else $error("sleep entered with charger present");
    nv_copy_a: assert property (
        COPY_DATA |=> NV_WR_STB) else $error("copy strobe missing");
    opcode_set_a: assert property (
        NET_ADDR_OPCODE == 8'h33 || NET_ADDR_OPCODE == 8'h39)
        else $error("net address opcode out of set");
    dq_pull_a: assert property (
        DQ_PULLDOWN_EN == !DQ_PULLUP_EN) else $error("data pin pulls clash");
    // the pullups belong to sleep only; one cycle grace after wake
    awake_pull_a: assert property (
        ACTIVE && $past(ACTIVE) |-> !DQ_PULLUP_EN && !PIO_PULLUP_EN)
        else $error("wake pullup on while active");
endmodule
bind pmc_power_mode_ctrl pmc_monitor i_pmc_monitor (.CLK(CLK),
    .RST_N(RST_N), .CHARGER_DET(CHARGER_DET), .SHA_REQ(SHA_REQ),
    .COPY_DATA(COPY_DATA), .ACTIVE(ACTIVE), .MEAS_EN(MEAS_EN),
    .CHARGE_SWITCH_DRIVE(CHARGE_SWITCH_DRIVE),
    .DISCHARGE_SWITCH_DRIVE(DISCHARGE_SWITCH_DRIVE),
    .SHA_START(SHA_START), .SHA_REFUSED(SHA_REFUSED),
    .NV_WR_STB(NV_WR_STB), .DQ_PULLDOWN_EN(DQ_PULLDOWN_EN),
    .DQ_PULLUP_EN(DQ_PULLUP_EN), .PIO_PULLUP_EN(PIO_PULLUP_EN),
    .NET_ADDR_OPCODE(NET_ADDR_OPCODE));

/* pmc_host_model.sv */
// bus host and wake-switch model resolving the data and programmable pins
// assumes pull controls come straight from the controller outputs
`timescale 1ns/1ps
module pmc_host_model (
    // clock
    input wire logic clk,
    // host and switch commands
    input wire logic host_en,
    input wire logic host_lvl,
    input wire logic sw_dq,
    input wire logic sw_pio,
    // pulls from the controller
    input wire logic dq_pu,
    input wire logic dq_pd,
    input wire logic pio_pu,
    // resolved pin levels
    output logic dq,
    output logic programmable_wake_pin
);
    logic flip_ff = 1'b0;
    // an unpulled pin changes every cycle, never holds a stale level
    always @(posedge clk) flip_ff <= ~flip_ff;
    // host drive wins, then a closed switch, then the weak pulls
    always_comb begin
        if (host_en) dq = host_lvl;
        else if (sw_dq) dq = 1'b0;
        else if (dq_pu) dq = 1'b1;
        else if (dq_pd) dq = 1'b0;
        else dq = flip_ff;
        if (sw_pio) programmable_wake_pin = 1'b0;
        else if (pio_pu) programmable_wake_pin = 1'b1;
        else programmable_wake_pin = flip_ff;
    end
endmodule

/* tb.sv */
// self-checking bench for the power-mode controller with host model
// assumes short sleep and debounce counts set at the instance
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst_n = 1'b0, host_en = 1'b1, host_lvl = 1'b1;
    logic sw_dq = 1'b0, sw_pio = 1'b0, chg = 1'b0, cur = 1'b0, uv = 1'b0;
    logic cc_safe = 1'b1, dc_safe = 1'b1, wr = 1'b0, copy = 1'b0;
    logic cur_vld = 1'b0, sha_req = 1'b0, dq, programmable_wake_pin, dq_pd, dq_pu, pio_pu;
    logic ccd, dcd, nv_stb, meas, sha_st, sha_ref, act;
    logic [7:0] addr = 8'h00, wdata = 8'h00, nv_cfg = 8'h10, rdata;
    logic [7:0] nv_data, opc, rd;
    logic signed [15:0] cur_raw = 16'sh0000, cur_out;
    int n_mismatch = 0, compares = 0;
    always #10 clk = ~clk;
    pmc_host_model i_pmc_host_model (.clk(clk), .host_en(host_en),
        .host_lvl(host_lvl), .sw_dq(sw_dq), .sw_pio(sw_pio), .dq_pu(dq_pu),
        .dq_pd(dq_pd), .pio_pu(pio_pu), .dq(dq), .programmable_wake_pin(programmable_wake_pin));
    pmc_power_mode_ctrl #(.SLEEP_CYC(20), .DEBOUNCE_CYC(8))
        i_pmc_power_mode_ctrl (.CLK(clk), .RST_N(rst_n), .DQ_IN(dq),
        .PIO_IN(programmable_wake_pin), .CHARGER_DET(chg), .CHG_CURRENT_DET(cur),
        .UNDERV_DET(uv), .CC_SAFE(cc_safe), .DC_SAFE(dc_safe),
        .DQ_PULLDOWN_EN(dq_pd), .DQ_PULLUP_EN(dq_pu), .PIO_PULLUP_EN(pio_pu),
        .CHARGE_SWITCH_DRIVE(ccd), .DISCHARGE_SWITCH_DRIVE(dcd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RDATA(rdata),
        .NV_CFG(nv_cfg), .COPY_DATA(copy), .NV_WR_STB(nv_stb),
        .NV_WR_DATA(nv_data), .CURRENT_RAW(cur_raw), .CURRENT_VALID(cur_vld),
        .CURRENT_OUT(cur_out), .MEAS_EN(meas), .SHA_REQ(sha_req),
        .SHA_START(sha_st), .SHA_REFUSED(sha_ref), .ACTIVE(act),
        .NET_ADDR_OPCODE(opc));
    task automatic chk(input string nm, input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one-cycle write strobe, launched and dropped off the sampling edge
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        rd = rdata;
    endtask
    // bounded wait on the mode flag, then judge it
    task automatic wait_act(input logic v, input int lim);
        for (int i = 0; i < lim && act !== v; i++) @(negedge clk);
        chk("active", act, v);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle request pulse, answer looked at the next cycle
    task automatic sha_try(input logic exp_st);
        @(negedge clk);
        sha_req = 1'b1;
        @(negedge clk);
        sha_req = 1'b0;
        chk("sha_start", sha_st, exp_st);
        chk("sha_refused", sha_ref, !exp_st);
    endtask
    task automatic t_reset();
        chk("active", act, 1'b1);
        rd_reg(pmc_pkg::CTRL_REG_ADDR);
        chk("ctrl", rd, nv_cfg);
        chk("opcode", opc, 8'h39);
        rd_reg(pmc_pkg::PROT_REG_ADDR);
        chk("gate_en", rd[1:0], 2'h3);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr_reg(pmc_pkg::CTRL_REG_ADDR, 8'h00);
        rd_reg(pmc_pkg::CTRL_REG_ADDR);
        chk("ctrl", rd, 8'h00);
        chk("opcode", opc, 8'h33);
        rd_reg(8'h42);
        chk("unmapped", rd, 8'h00);
        wr_reg(pmc_pkg::PROT_REG_ADDR, 8'h00);
        idle(2);
        chk("drives", {ccd, dcd}, 2'h0);
        wr_reg(pmc_pkg::PROT_REG_ADDR, 8'h03);
        cc_safe = 1'b0;
        idle(5);
        chk("drives", {ccd, dcd}, 2'h1);
        cc_safe = 1'b1;
        idle(5);
        chk("drives", {ccd, dcd}, 2'h3);
        sha_try(1'b1);
        $display("test registers done");
    endtask
    // bus-low sleep, glitch rejection, pin wake, then charger wake
    task automatic t_bus_sleep();
        wr_reg(pmc_pkg::CTRL_REG_ADDR, 8'h20);
        wr_reg(pmc_pkg::PROT_REG_ADDR, 8'h00);
        host_en = 1'b0;
        idle(15);
        chk("active", act, 1'b1);
        wait_act(1'b0, 40);
        chk("drives", {ccd, dcd, meas}, 3'h0);
        sha_try(1'b0);
        host_en = 1'b1;
        idle(4);
        host_en = 1'b0;
        idle(12);
        chk("active", act, 1'b0);
        host_en = 1'b1;
        idle(6);
        chk("active", act, 1'b0);
        wait_act(1'b1, 30);
        rd_reg(pmc_pkg::PROT_REG_ADDR);
        chk("gate_en", rd[1:0], 2'h3);
        host_en = 1'b0;
        wait_act(1'b0, 60);
        chk("drives", {ccd, dcd}, 2'h0);
        chg = 1'b1;
        wait_act(1'b1, 12);
        host_en = 1'b1;
        chg = 1'b0;
        $display("test bus sleep done");
    endtask
    // no sleep with the enable clear or a charger present
    task automatic t_blocked();
        for (int i = 0; i < 3; i++) begin
            wr_reg(pmc_pkg::CTRL_REG_ADDR, i == 0 ? 8'h00 : 8'h20);
            chg = (i == 1);
            cur = (i == 2);
            host_en = 1'b0;
            idle(60);
            chk("active", act, 1'b1);
            host_en = 1'b1;
            chg = 1'b0;
            cur = 1'b0;
        end
        $display("test blocked done");
    endtask
    task automatic t_uv_sleep();
        wr_reg(pmc_pkg::CTRL_REG_ADDR, 8'h40);
        uv = 1'b1;
        wait_act(1'b0, 60);
        host_lvl = 1'b0;
        wait_act(1'b1, 30);
        uv = 1'b0;
        host_lvl = 1'b1;
        $display("test undervoltage sleep done");
    endtask
    // power-switch wake on each pin in turn, the other pin left idle
    task automatic t_pio_wake();
        for (int i = 0; i < 2; i++) begin
            wr_reg(pmc_pkg::CTRL_REG_ADDR, i == 0 ? 8'h24 : 8'h22);
            host_en = 1'b0;
            wait_act(1'b0, 60);
            idle(3);
            chk("pio_pullup", pio_pu, i == 0);
            chk("dq_pullup", dq_pu, i == 1);
            chk("dq_pulldown", dq_pd, i == 0);
            sw_pio = (i == 0);
            sw_dq = (i == 1);
            idle(6);
            chk("active", act, 1'b0);
            wait_act(1'b1, 30);
            host_en = 1'b1;
            sw_pio = 1'b0;
            sw_dq = 1'b0;
        end
        $display("test pio wake done");
    endtask
    // blanking boundary sits at the blank limit of 16 counts
    task automatic t_blank();
        logic [15:0] raw [3] = '{16'hfff0, 16'hffef, 16'hfff0};
        logic [15:0] exp [3] = '{16'h0000, 16'hffef, 16'hfff0};
        for (int i = 0; i < 3; i++) begin
            wr_reg(pmc_pkg::CTRL_REG_ADDR, i < 2 ? 8'h80 : 8'h00);
            cur_raw = raw[i];
            cur_vld = 1'b1;
            @(negedge clk);
            cur_vld = 1'b0;
            chk("current", cur_out, exp[i]);
        end
        copy = 1'b1;
        @(negedge clk);
        copy = 1'b0;
        chk("nv_write", {nv_stb, nv_data}, 9'h100);
        $display("test blanking and copy done");
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        idle(3);
        rst_n = 1'b1;
        idle(4);
        t_reset();
        t_regs();
        t_bus_sleep();
        t_blocked();
        t_uv_sleep();
        t_pio_wake();
        t_blank();
        results();
    end
    // whole run is under a thousand cycles; this bound of 10000 cycles means a hang
    initial begin
        #(20 * 10000);
        n_mismatch++;
        results();
    end
endmodule
